// file: ttc_combiner.sv
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
module ttc_combiner import ttc_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire ttc_bus_req_t avs_req_in,
  output logic avs_waitrequest_out,
  output logic [31:0] avs_readdata_out,
  output logic irq_out,
  input wire ttc_sample_t sample_in,
  output ttc_sample_t sample_out,
  output logic match_out,
  output logic trigger_out,
  output logic [3:0] level_out
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [1:0] ctrl_r;
  logic [2:0] stat_r;
  logic [2:0] mask_r;
  logic [3:0] lvl_cnt_r;
  logic [3:0] trig_lvl_r;
  logic [31:0] termsel_r;
  logic [23:0] pairop_r;
  logic [2:0] grpop_r;
  logic [3:0] rngsel_r;
  logic [5:0] edgek_r;
  logic [31:0] edgem_r [2];
  logic [31:0] preset_r [2];
  logic [31:0] rlo_r [2];
  logic [31:0] rhi_r [2];
  logic [31:0] patv_r [NUM_PAT];
  logic [31:0] patm_r [NUM_PAT];
  logic wait_r;
  logic [31:0] rdata_r;
  logic irq_r;
  ttc_seq_t seq_r;
  logic [3:0] level_r;
  logic trig_done_r;
  logic trig_pulse_r;
  logic match_r;
  ttc_sample_t smp_r;
  logic [31:0] prev_r;
  logic [31:0] tcnt_r [2];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire req = avs_req_in.read | avs_req_in.write;
  wire [7:0] addr = avs_req_in.address;
  wire acc = req && !wait_r;
  wire wr = acc && avs_req_in.write;
  wire pat_reg = addr[7];
  wire [3:0] pat_idx = addr[6:3];
  wire pat_ok = pat_reg && (pat_idx < 4'(NUM_PAT)) && (addr[1:0] == 2'h0);
  wire [3:0] pidx = pat_ok ? pat_idx : 4'h0;
  wire [31:0] bmask = {{8{avs_req_in.byteenable[3]}}, {8{avs_req_in.byteenable[2]}},
                       {8{avs_req_in.byteenable[1]}}, {8{avs_req_in.byteenable[0]}}};
  logic [31:0] rmux;
  wire [31:0] wd = (rmux & ~bmask) | (avs_req_in.writedata & bmask);
  wire timing = ctrl_r[CTRL_TIMING_BIT];

  always_comb begin
    rmux = 32'h0000_0000;
    case (addr)
      REG_CTRL: rmux = {30'h0, ctrl_r};
      REG_STATUS: rmux = {29'h0, stat_r};
      REG_MASK: rmux = {29'h0, mask_r};
      REG_LEVELS: rmux = {20'h0, trig_lvl_r, 4'h0, lvl_cnt_r};
      REG_TERMSEL: rmux = termsel_r;
      REG_PAIROP: rmux = {8'h0, pairop_r};
      REG_GROUPOP: rmux = {29'h0, grpop_r};
      REG_RANGESEL: rmux = {28'h0, rngsel_r};
      REG_EDGEKIND: rmux = {26'h0, edgek_r};
      REG_EDGEMASK0: rmux = edgem_r[0];
      REG_EDGEMASK1: rmux = edgem_r[1];
      REG_PRESET0: rmux = preset_r[0];
      REG_PRESET1: rmux = preset_r[1];
      REG_SEQSTAT: rmux = {22'h0, seq_r, trig_done_r, 3'h0, level_r};
      REG_RLO0: rmux = rlo_r[0];
      REG_RHI0: rmux = rhi_r[0];
      REG_RLO1: rmux = rlo_r[1];
      REG_RHI1: rmux = rhi_r[1];
      default: begin
        if (pat_ok) begin
          rmux = addr[2] ? patm_r[pidx] : patv_r[pidx];
        end
      end
    endcase
  end

  // ----------------------------------------
  // configuration checks
  // ----------------------------------------
  logic [7:0] ts_bad;
  logic [7:0] po_bad;
  for (genvar i = 0; i < 8; i++) begin : g_chk
    assign ts_bad[i] = (wd[4*i+:2] == TOP_BAD) || (wd[4*i+2+:2] == TOP_BAD); // [RULE_04]
    assign po_bad[i] = (i < NUM_PAIR) && (wd[3*i+:3] > PAIR_XNOR); // [RULE_02]
  end
  wire hj_used = (wd[21:20] != TOP_OFF) || (wd[29:28] != TOP_OFF);
  wire edge_used = (wd[11:10] != TOP_OFF) || (wd[27:26] != TOP_OFF);
  wire ts_refuse = (|ts_bad) || (timing && hj_used) || (!timing && edge_used); // [RULE_08] [RULE_12]
  wire [3:0] n_cnt = wd[3:0];
  wire [3:0] n_trig = wd[LVL_TRIG_POS+:4];
  wire [3:0] lvl_max = timing ? LVL_MAX_TIMING : LVL_MAX_STATE; // [RULE_06] [RULE_10]
  wire trig_ok = timing ? (n_trig == n_cnt - 4'h1) : (n_trig < n_cnt - 4'h1); // [RULE_07] [RULE_11]
  wire lvl_refuse = (n_cnt < LVL_MIN) || (n_cnt > lvl_max) || !trig_ok;
  wire rng_refuse = (wd[1:0] == RANGE_BAD) || (wd[3:2] == RANGE_BAD); // [RULE_05]
  wire ek_refuse = (wd[2:0] > EDGE_NONE) || (wd[5:3] > EDGE_NONE); // [RULE_09]
  logic refuse;
  always_comb begin
    refuse = 1'b0;
    case (addr)
      REG_TERMSEL: refuse = ts_refuse; // [RULE_13]
      REG_PAIROP: refuse = |po_bad; // [RULE_13]
      REG_LEVELS: refuse = lvl_refuse; // [RULE_13]
      REG_RANGESEL: refuse = rng_refuse; // [RULE_13]
      REG_EDGEKIND: refuse = ek_refuse; // [RULE_13]
      default: refuse = 1'b0;
    endcase
  end
  wire wr_ok = wr && !refuse;

  // ----------------------------------------
  // term evaluation
  // ----------------------------------------
  wire [31:0] cur = sample_in.pods[PAT_W-1:0];
  logic [NUM_PAT-1:0] pat_hit;
  for (genvar k = 0; k < NUM_PAT; k++) begin : g_pat
    assign pat_hit[k] = ((cur ^ patv_r[k]) & patm_r[k]) == 32'h0000_0000;
  end
  logic [1:0] rng_in;
  logic [1:0] edge_hit;
  logic [1:0] tmr_lt;
  logic [1:0] tmr_gt;
  for (genvar r = 0; r < 2; r++) begin : g_rt
    wire [1:0] psel = rngsel_r[2*r+:2];
    wire [31:0] rv = sample_in.pods[32*psel+:32]; // [RULE_05]
    assign rng_in[r] = (rv >= rlo_r[r]) && (rv <= rhi_r[r]);
    wire [31:0] m = edgem_r[r];
    wire rise = |(cur & ~prev_r & m);
    wire fall = |(~cur & prev_r & m);
    wire glit = |(sample_in.glitch & m);
    logic eh;
    always_comb begin
      eh = 1'b0;
      case (edgek_r[3*r+:3]) // [RULE_09]
        EDGE_GLITCH: eh = glit;
        EDGE_RISE: eh = rise;
        EDGE_FALL: eh = fall;
        EDGE_EITHER: eh = rise | fall;
        EDGE_NONE: eh = !(rise | fall);
        default: eh = 1'b0;
      endcase
    end
    assign edge_hit[r] = eh;
    assign tmr_lt[r] = tcnt_r[r] < preset_r[r];
    assign tmr_gt[r] = tcnt_r[r] > preset_r[r];
  end
  // resources in pair order: a b c rng0 d edge0 e tmr0 f g h rng1 i edge1 j tmr1
  wire [NUM_RES-1:0] t_raw = {tmr_lt[1], pat_hit[9], edge_hit[1], pat_hit[8], rng_in[1], pat_hit[7],
                              pat_hit[6], pat_hit[5], tmr_lt[0], pat_hit[4], edge_hit[0], pat_hit[3],
                              rng_in[0], pat_hit[2], pat_hit[1], pat_hit[0]}; // [RULE_01]
  wire [NUM_RES-1:0] t_alt = {tmr_gt[1], ~t_raw[14:8], tmr_gt[0], ~t_raw[6:0]}; // [RULE_04]
  wire lvl0 = (level_r == 4'h0);
  wire [NUM_RES-1:0] t_ok = ~({1'b0, timing, !timing, 1'b0, 1'b0, timing, 10'h000}
                              | {1'b0, 9'h000, !timing, 5'h00} // [RULE_08] [RULE_12]
                              | {lvl0, 7'h00, lvl0, 7'h00}); // [RULE_14]
  logic [NUM_RES-1:0] t_act;
  logic [NUM_RES-1:0] t_val;
  for (genvar i = 0; i < NUM_RES; i++) begin : g_term
    wire [1:0] op = termsel_r[2*i+:2];
    assign t_act[i] = (op != TOP_OFF) && t_ok[i]; // [RULE_04]
    assign t_val[i] = (op == TOP_ON) ? t_raw[i] : t_alt[i];
  end

  // ----------------------------------------
  // pair, group and top combination
  // ----------------------------------------
  function automatic logic [1:0] pair_f(input logic [2:0] op, input logic av, input logic a,
                                        input logic bv, input logic b);
    logic r;
    r = 1'b0;
    case (op)
      PAIR_AND: r = a & b;
      PAIR_NAND: r = !(a & b);
      PAIR_OR: r = a | b;
      PAIR_NOR: r = !(a | b);
      PAIR_XNOR: r = !(a ^ b);
      default: r = 1'b0;
    endcase
    if (!av) begin
      r = b;
    end else if (!bv) begin
      r = a;
    end
    return {av | bv, r};
  endfunction

  function automatic logic [1:0] grp_f(input logic op, input logic [3:0] v, input logic [3:0] x);
    logic r;
    r = op ? |(x & v) : &(x | ~v);
    return {|v, r};
  endfunction

  logic [NUM_PAIR-1:0] p_v;
  logic [NUM_PAIR-1:0] p_x;
  for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
    assign {p_v[p], p_x[p]} = pair_f(pairop_r[3*p+:3], t_act[2*p], t_val[2*p],
                                     t_act[2*p+1], t_val[2*p+1]); // [RULE_01] [RULE_02]
  end
  wire [1:0] g0 = grp_f(grpop_r[0], p_v[3:0], p_x[3:0]); // [RULE_03]
  wire [1:0] g1 = grp_f(grpop_r[1], p_v[7:4], p_x[7:4]); // [RULE_03]
  wire [1:0] top = grp_f(grpop_r[2], {2'h0, g1[1], g0[1]}, {2'h0, g1[0], g0[0]}); // [RULE_03]
  wire expr = top[1] & top[0];

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire running = (seq_r == SEQ_RUN);
  wire last_lvl = (level_r == lvl_cnt_r - 4'h1);
  wire at_trig = (level_r == trig_lvl_r) && !trig_done_r;
  wire ev_trig = running && expr && at_trig; // [RULE_15]
  wire ev_done = running && expr && last_lvl;
  wire arm_wr = wr_ok && (addr == REG_CTRL);
  wire arm_set = arm_wr && wd[CTRL_ARM_BIT];
  ttc_seq_t seq_nxt;
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      SEQ_IDLE: if (arm_set) seq_nxt = SEQ_RUN;
      SEQ_RUN: if (arm_wr && !wd[CTRL_ARM_BIT]) seq_nxt = SEQ_IDLE; else if (ev_done) seq_nxt = SEQ_DONE;
      SEQ_DONE: if (arm_wr) seq_nxt = arm_set ? SEQ_RUN : SEQ_IDLE;
      default: seq_nxt = SEQ_IDLE;
    endcase
  end
  wire restart = (seq_r != SEQ_RUN) && (seq_nxt == SEQ_RUN);
  wire adv = running && expr && !last_lvl; // [RULE_15]
  wire [3:0] level_nxt = restart ? 4'h0 : (adv ? level_r + 4'h1 : level_r);
  wire lvl_chg = restart || adv;
  wire [2:0] ev = {wr && refuse, ev_done, ev_trig};
  wire [2:0] w1c = (wr_ok && addr == REG_STATUS) ? wd[2:0] : 3'h0;
  wire [2:0] stat_nxt = (stat_r & ~w1c) | ev;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      seq_r <= SEQ_IDLE;
      level_r <= 4'h0;
      trig_done_r <= 1'b0;
      trig_pulse_r <= 1'b0;
      match_r <= 1'b0;
      smp_r <= '0;
      prev_r <= ZERO_RST;
      stat_r <= 3'h0;
      irq_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= ZERO_RST;
    end else if (ce_in) begin
      seq_r <= seq_nxt;
      level_r <= level_nxt;
      trig_done_r <= restart ? 1'b0 : (trig_done_r | ev_trig); // [RULE_15]
      trig_pulse_r <= ev_trig;
      match_r <= expr; // [RULE_16]
      smp_r <= sample_in; // [RULE_16]
      prev_r <= cur;
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask_r);
      wait_r <= !(req && wait_r);
      if (req && wait_r) begin
        rdata_r <= rmux;
      end
    end
  end

  for (genvar t = 0; t < 2; t++) begin : g_tmr
    always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
        tcnt_r[t] <= ZERO_RST;
      end else if (ce_in) begin
        if (lvl_chg || !running) begin
          tcnt_r[t] <= ZERO_RST;
        end else if (tcnt_r[t] != 32'hffff_ffff) begin
          tcnt_r[t] <= tcnt_r[t] + 32'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      ctrl_r <= 2'h0;
      mask_r <= 3'h0;
      lvl_cnt_r <= LVL_CNT_RST;
      trig_lvl_r <= TRIG_LVL_RST;
      termsel_r <= ZERO_RST;
      pairop_r <= 24'h0;
      grpop_r <= 3'h0;
      rngsel_r <= 4'h0;
      edgek_r <= 6'h0;
    end else if (ce_in && wr_ok) begin
      case (addr)
        REG_CTRL: ctrl_r <= wd[1:0];
        REG_MASK: mask_r <= wd[2:0];
        REG_LEVELS: begin
          lvl_cnt_r <= n_cnt;
          trig_lvl_r <= n_trig;
        end
        REG_TERMSEL: termsel_r <= wd;
        REG_PAIROP: pairop_r <= wd[23:0];
        REG_GROUPOP: grpop_r <= wd[2:0];
        REG_RANGESEL: rngsel_r <= wd[3:0];
        REG_EDGEKIND: edgek_r <= wd[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 2; i++) begin
        edgem_r[i] <= ZERO_RST;
        preset_r[i] <= ZERO_RST;
        rlo_r[i] <= ZERO_RST;
        rhi_r[i] <= ZERO_RST;
      end
      for (int k = 0; k < NUM_PAT; k++) begin
        patv_r[k] <= ZERO_RST;
        patm_r[k] <= ZERO_RST;
      end
    end else if (ce_in && wr_ok) begin
      case (addr)
        REG_EDGEMASK0: edgem_r[0] <= wd;
        REG_EDGEMASK1: edgem_r[1] <= wd;
        REG_PRESET0: preset_r[0] <= wd;
        REG_PRESET1: preset_r[1] <= wd;
        REG_RLO0: rlo_r[0] <= wd;
        REG_RHI0: rhi_r[0] <= wd;
        REG_RLO1: rlo_r[1] <= wd;
        REG_RHI1: rhi_r[1] <= wd;
        default: begin
          if (pat_ok && addr[2]) begin
            patm_r[pidx] <= wd;
          end else if (pat_ok) begin
            patv_r[pidx] <= wd;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avs_waitrequest_out = wait_r;
  assign avs_readdata_out = rdata_r;
  assign irq_out = irq_r;
  assign sample_out = smp_r;
  assign match_out = match_r;
  assign trigger_out = trig_pulse_r;
  assign level_out = level_r;
endmodule

// file: ttc_pkg.sv
// Summary of operation
// RULE_01: resources form two groups of four pairs; combining stays inside a pair.
// RULE_02: a pair joins its two resources by and, nand, or, nor or xnor.
// RULE_03: pairs join within a group, then groups join, by and or or only.
// RULE_04: each resource selects off, on or negate; range in/out; timer less/greater.
// RULE_05: a range spans only pod pairs 1/2, 3/4 or 5/6.
// RULE_06: timing mode offers at most 10 sequence levels.
// RULE_07: timing mode puts the trigger at the final level.
// RULE_08: timing mode cannot use pattern terms h and j; state mode can.
// RULE_09: edge terms detect glitch, rise, fall, either or no edge over ored channels.
// RULE_10: state mode offers at most 12 sequence levels.
// RULE_11: state mode never puts the trigger at the final level.
// RULE_12: state mode cannot use the two edge terms.
// RULE_13: configuration writes breaking any combination limit are refused; a mode change written to REG_CTRL is not checked.
// RULE_14: timers are unusable at the first sequence level.
// RULE_15: a trigger locks acquisition memory, then the sequencer advances a level.
// RULE_16: the expression is evaluated each sample and shown with that sample.
package ttc_pkg;
  localparam int POD_W = 16;
  localparam int NUM_PODS = 6;
  localparam int SMP_W = POD_W * NUM_PODS;
  localparam int PAT_W = 32;
  localparam int NUM_PAT = 10;
  localparam int NUM_RES = 16;
  localparam int NUM_PAIR = 8;
  localparam logic [3:0] LVL_MAX_TIMING = 4'ha;
  localparam logic [3:0] LVL_MAX_STATE = 4'hc;
  localparam logic [3:0] LVL_MIN = 4'h2;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_LEVELS = 8'h0c;
  localparam logic [7:0] REG_TERMSEL = 8'h10;
  localparam logic [7:0] REG_PAIROP = 8'h14;
  localparam logic [7:0] REG_GROUPOP = 8'h18;
  localparam logic [7:0] REG_RANGESEL = 8'h1c;
  localparam logic [7:0] REG_EDGEKIND = 8'h20;
  localparam logic [7:0] REG_EDGEMASK0 = 8'h24;
  localparam logic [7:0] REG_EDGEMASK1 = 8'h28;
  localparam logic [7:0] REG_PRESET0 = 8'h2c;
  localparam logic [7:0] REG_PRESET1 = 8'h30;
  localparam logic [7:0] REG_SEQSTAT = 8'h34;
  localparam logic [7:0] REG_RLO0 = 8'h38;
  localparam logic [7:0] REG_RHI0 = 8'h3c;
  localparam logic [7:0] REG_RLO1 = 8'h40;
  localparam logic [7:0] REG_RHI1 = 8'h44;
  localparam logic [7:0] REG_PAT_BASE = 8'h80;
  // field positions
  localparam int CTRL_TIMING_BIT = 0;
  localparam int CTRL_ARM_BIT = 1;
  localparam int ST_TRIG_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_REFUSE_BIT = 2;
  localparam int LVL_TRIG_POS = 8;
  localparam int SEQ_TRIG_POS = 8;
  // reset values
  localparam logic [3:0] LVL_CNT_RST = 4'h2;
  localparam logic [3:0] TRIG_LVL_RST = 4'h0;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  // resource operation codes
  localparam logic [1:0] TOP_OFF = 2'h0;
  localparam logic [1:0] TOP_ON = 2'h1;
  localparam logic [1:0] TOP_BAD = 2'h3;
  localparam logic [2:0] PAIR_AND = 3'h0;
  localparam logic [2:0] PAIR_NAND = 3'h1;
  localparam logic [2:0] PAIR_OR = 3'h2;
  localparam logic [2:0] PAIR_NOR = 3'h3;
  localparam logic [2:0] PAIR_XNOR = 3'h4;
  localparam logic [2:0] EDGE_GLITCH = 3'h0;
  localparam logic [2:0] EDGE_RISE = 3'h1;
  localparam logic [2:0] EDGE_FALL = 3'h2;
  localparam logic [2:0] EDGE_EITHER = 3'h3;
  localparam logic [2:0] EDGE_NONE = 3'h4;
  localparam logic [1:0] RANGE_BAD = 2'h3;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} ttc_seq_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ttc_bus_req_t;
  typedef struct packed {
    logic [SMP_W-1:0] pods;
    logic [PAT_W-1:0] glitch;
  } ttc_sample_t;
endpackage

// file: ttc_probe_model.sv
`timescale 1ns/100ps
module ttc_probe_model import ttc_pkg::*; (
  input wire logic clock_in,
  input wire logic drive_in,
  input wire logic [31:0] chan_in,
  input wire logic [63:0] upper_in,
  output ttc_sample_t sample_out
);
  // ----------------------------------------
  // probed target, noise while released
  // ----------------------------------------
  logic [SMP_W-1:0] hold_r = '0;
  always @(posedge clock_in) begin
    hold_r <= drive_in ? ~{upper_in, chan_in} : ~hold_r;
  end
  assign sample_out.pods = drive_in ? {upper_in, chan_in} : hold_r;
  assign sample_out.glitch = drive_in ? 32'h0 : hold_r[31:0];
endmodule

// file: ttc_combiner_checker.sv
`timescale 1ns/100ps
module ttc_combiner_checker import ttc_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire ttc_bus_req_t avs_req_in,
  input wire logic avs_waitrequest_out,
  input wire logic [31:0] avs_readdata_out,
  input wire logic irq_out,
  input wire ttc_sample_t sample_in,
  input wire ttc_sample_t sample_out,
  input wire logic match_out,
  input wire logic trigger_out,
  input wire logic [3:0] level_out
);
  // ----------------------------------------
  // port properties
  // ----------------------------------------
  wire bus_req = avs_req_in.read | avs_req_in.write;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_ask;
    bus_req && avs_waitrequest_out && ce_in;
  endsequence
  sequence s_rd_hole;
    avs_req_in.read && avs_req_in.address == 8'h60 && avs_waitrequest_out && ce_in ##1 !avs_waitrequest_out;
  endsequence
  property p_ack;
    s_ask |=> !avs_waitrequest_out;
  endproperty
  property p_one_wait;
    !avs_waitrequest_out && ce_in |=> avs_waitrequest_out;
  endproperty
  property p_idle;
    !bus_req && ce_in |=> avs_waitrequest_out;
  endproperty
  property p_hole;
    s_rd_hole |-> avs_readdata_out == 32'h0;
  endproperty
  property p_rst;
    disable iff (1'b0) !rst_b_in && ce_in |=> avs_waitrequest_out && !irq_out && !match_out && !trigger_out
      && level_out == 4'h0 && sample_out == '0;
  endproperty
  property p_sample;
    ce_in && rst_b_in |=> sample_out == $past(sample_in);
  endproperty
  property p_trig;
    trigger_out && ce_in |-> match_out ##1 !trigger_out;
  endproperty
  property p_lvl_cap;
    level_out <= 4'hb;
  endproperty
  property p_lvl_step;
    level_out != $past(level_out) |-> level_out == $past(level_out) + 4'h1 || level_out == 4'h0;
  endproperty
  property p_lvl_match;
    level_out == $past(level_out) + 4'h1 |-> match_out;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer to request");
  a_one_wait: assert property (p_one_wait) else $error("answer held too long");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_hole: assert property (p_hole) else $error("hole read not zero");
  a_rst: assert property (p_rst) else $error("bad reset value");
  a_sample: assert property (p_sample) else $error("sample not delayed one cycle");
  a_trig: assert property (p_trig) else $error("bad trigger pulse");
  a_lvl_cap: assert property (p_lvl_cap) else $error("level beyond limit");
  a_lvl_step: assert property (p_lvl_step) else $error("level jumped");
  a_lvl_match: assert property (p_lvl_match) else $error("level advanced without match");
endmodule
bind ttc_combiner ttc_combiner_checker u_ttc_combiner_checker (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .avs_req_in(avs_req_in),
  .avs_waitrequest_out(avs_waitrequest_out), .avs_readdata_out(avs_readdata_out), .irq_out(irq_out),
  .sample_in(sample_in), .sample_out(sample_out), .match_out(match_out), .trigger_out(trigger_out),
  .level_out(level_out)
);

// file: test_trigger_term_combiner.sv
`timescale 1ns/100ps
module test_trigger_term_combiner import ttc_pkg::*;;
  // ----------------------------------------
  // stimulus and scoreboard
  // ----------------------------------------
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce_in = 1'b1;
  logic drive = 1'b0;
  logic vld = 1'b0;
  logic vld_d = 1'b0;
  logic [31:0] chan = 32'h0;
  logic [63:0] upper = 64'h0;
  ttc_bus_req_t req = '0;
  ttc_sample_t smp, smp_q;
  logic waitreq, irq, match, trig;
  logic [31:0] rdata;
  logic [3:0] level;
  int error_cnt = 0;
  int tests_run = 0;
  int trig_cnt = 0;
  logic [31:0] rd_q[$];
  logic mt_q[$];
  logic [4:0] hit = 5'h0e;
  logic [0:11] tm = 12'hc38;
  logic [7:0] ra[8] = '{REG_CTRL, REG_STATUS, REG_MASK, REG_LEVELS, REG_TERMSEL, REG_PAIROP, REG_SEQSTAT, 8'h60};
  logic [7:0] pa[8] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'ha8, 8'hac};
  logic [31:0] pd[8] = '{32'h34, 32'hff, 32'habcd_0000, 32'hffff_0000, 32'h1200, 32'hff00, 32'habcd_0000,
    32'hffff_0000};
  logic [7:0] ta[12] = '{REG_TERMSEL, REG_TERMSEL, REG_TERMSEL, REG_TERMSEL, REG_PAIROP, REG_RANGESEL,
    REG_EDGEKIND, REG_LEVELS, REG_LEVELS, REG_LEVELS, REG_LEVELS, REG_LEVELS};
  // h, j, edge, code 3, op 5, range 3, edge 5, 11 levels, trigger, 13 levels, last, 1 level
  logic [31:0] tg[12] = '{32'h1, 32'h1, 32'h10_0001, 32'h1, 32'h4, 32'ha, 32'h24, 32'h90a, 32'h809, 32'ha0c,
    32'ha0c, 32'h2};
  logic [31:0] tb[12] = '{32'h10_0001, 32'h1000_0001, 32'h401, 32'h3, 32'h5, 32'h3, 32'h5, 32'ha0b, 32'h709,
    32'hd, 32'hb0c, 32'h1};
  always #5 clock_in = ~clock_in;
  ttc_probe_model u_ttc_probe_model (.clock_in(clock_in), .drive_in(drive), .chan_in(chan), .upper_in(upper),
    .sample_out(smp));
  ttc_combiner u_ttc_combiner (.clock_in(clock_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .avs_req_in(req),
    .avs_waitrequest_out(waitreq), .avs_readdata_out(rdata), .irq_out(irq), .sample_in(smp),
    .sample_out(smp_q), .match_out(match), .trigger_out(trig), .level_out(level));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int n;
    req <= '{read: rd, write: !rd, address: a, writedata: rd ? 32'h0 : d, byteenable: 4'hf};
    if (rd) rd_q.push_back(d);
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      wrap_up();
    end
    req <= '0;
    @(posedge clock_in);
  endtask
  task automatic send(input logic [2:0] x, input logic e);
    chan <= {x[2] ? 16'habcd : 16'h0, x[1] ? 8'h12 : 8'h0, x[0] ? 8'h34 : 8'h0};
    upper <= {$urandom, $urandom};
    drive <= 1'b1;
    vld <= 1'b1;
    mt_q.push_back(e);
    @(posedge clock_in);
  endtask
  task automatic quiet();
    drive <= 1'b0;
    vld <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask
  function automatic logic pair_fn(input int op, input logic p, input logic q);
    case (op)
      0: return p & q;
      1: return !(p & q);
      2: return p | q;
      3: return !(p | q);
      default: return p ~^ q;
    endcase
  endfunction
  function automatic logic grp_fn(input logic [2:0] g, input logic [2:0] x);
    logic g1;
    g1 = g[0] ? (x[0] | x[1]) : (x[0] & x[1]);
    return g[2] ? (g1 | x[2]) : (g1 & x[2]);
  endfunction
  always @(posedge clock_in) begin
    if (req.read && waitreq === 1'b0) check("readdata", rdata, rd_q.pop_front());
    if (vld_d) check("match", {31'h0, match}, {31'h0, mt_q.pop_front()});
    if (trig === 1'b1) trig_cnt++;
    vld_d <= vld;
  end
  initial begin
    void'($urandom(94986));
    repeat (16) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    for (int i = 0; i < 8; i++) bus(1'b1, ra[i], ra[i] == REG_LEVELS ? 32'h2 : 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, pa[i], pd[i]);
      bus(1'b1, pa[i], pd[i]);
    end
    for (int nb = 0; nb < 2; nb++) begin
      bus(1'b0, REG_TERMSEL, nb ? 32'h9 : 32'h5);
      for (int op = 0; op < 5; op++) begin
        bus(1'b0, REG_PAIROP, 32'(op));
        for (int x = 0; x < 8; x++) send(x[2:0], pair_fn(op, x[0], x[2] ^ nb[0]));
        quiet();
      end
    end
    $display("test pair done");
    bus(1'b0, REG_TERMSEL, 32'h1_0011);
    for (int g = 0; g < 8; g++) begin
      bus(1'b0, REG_GROUPOP, 32'(g));
      for (int x = 0; x < 8; x++) send(x[2:0], grp_fn(g[2:0], x[2:0]));
      quiet();
    end
    $display("test group done");
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, REG_CTRL, {31'h0, tm[i]});
      bus(1'b0, ta[i], tg[i]);
      bus(1'b0, ta[i], tb[i]);
      bus(1'b1, ta[i], tg[i]);
      bus(1'b1, REG_STATUS, 32'h4);
      bus(1'b0, REG_STATUS, 32'h4);
    end
    $display("test refusal done");
    bus(1'b0, REG_LEVELS, 32'h103);
    bus(1'b0, REG_MASK, 32'h1);
    bus(1'b0, REG_TERMSEL, 32'h4000);
    bus(1'b0, REG_PRESET0, 32'h100);
    bus(1'b0, REG_CTRL, 32'h2);
    repeat (3) send(3'h0, 1'b0);
    quiet();
    bus(1'b1, REG_SEQSTAT, 32'h100);
    bus(1'b0, REG_TERMSEL, 32'h1);
    bus(1'b0, REG_CTRL, 32'h2);
    for (int k = 0; k < 5; k++) send({2'h0, hit[k]}, hit[k]);
    quiet();
    bus(1'b1, REG_SEQSTAT, 32'h282);
    bus(1'b1, REG_STATUS, 32'h3);
    check("triggers", 32'(trig_cnt), 32'h1);
    check("level", {28'h0, level}, 32'h2);
    check("irq", {31'h0, irq}, 32'h1);
    bus(1'b0, REG_MASK, 32'h0);
    repeat (2) @(posedge clock_in);
    check("irq", {31'h0, irq}, 32'h0);
    bus(1'b0, REG_MASK, 32'h3);
    bus(1'b0, REG_STATUS, 32'h3);
    repeat (2) @(posedge clock_in);
    check("irq", {31'h0, irq}, 32'h0);
    bus(1'b1, REG_STATUS, 32'h0);
    $display("test sequence done");
    bus(1'b0, REG_CTRL, 32'h0);
    bus(1'b0, REG_TERMSEL, 32'h10_0000);
    send(3'($urandom), 1'b1);
    quiet();
    bus(1'b0, REG_CTRL, 32'h1);
    send(3'($urandom), 1'b0);
    quiet();
    bus(1'b0, REG_TERMSEL, 32'h400);
    send(3'($urandom), 1'b1);
    quiet();
    bus(1'b0, REG_EDGEMASK0, 32'h4);
    bus(1'b0, REG_EDGEKIND, 32'h21);
    for (int k = 0; k < 3; k++) send({2'h0, k == 1}, k == 1);
    quiet();
    bus(1'b0, REG_CTRL, 32'h0);
    send(3'($urandom), 1'b0);
    quiet();
    $display("test mode done");
    wrap_up();
  end
endmodule
